// ---- carc_pkg.sv ----
package carc_pkg;
  // Cache geometry
  localparam int CARC_WAYS = 4;
  localparam int CARC_SETS = 64;
  localparam int CARC_WORDS = 4;
  localparam int CARC_IDX_W = 6;
  localparam int CARC_TAG_W = 22;
  localparam int CARC_FIFO_DEPTH = 4;
  // Reset values
  localparam logic [1:0] CARC_RR_RST = 2'h0;
  localparam logic [1:0] CARC_WCNT_RST = 2'h0;
  // Snoop operation encodings
  localparam logic [1:0] CARC_SNP_NONE = 2'h0;
  localparam logic [1:0] CARC_SNP_SRC = 2'h1;
  localparam logic [1:0] CARC_SNP_INV = 2'h2;
  // Reset-out hold time
  localparam int CARC_EXTERNAL_RESET_OUT_NS = 5120;
  localparam int CARC_CLK_NS = 10;
  localparam int CARC_EXTERNAL_RESET_OUT_CYC = CARC_EXTERNAL_RESET_OUT_NS / CARC_CLK_NS;
  typedef enum logic [2:0] {CARC_IDLE, CARC_PUSH, CARC_FILL, CARC_WTHR, CARC_SNPS} carc_state_t;
endpackage

// ---- carc_fifo.sv ----
module carc_fifo import carc_pkg::*; #(
  parameter int WIDTH = 32,
  parameter int DEPTH = CARC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_b) cnt_r <= (AW+1)'(DEPTH))
    else $error("fifo count over depth");
endmodule

// ---- carc_rst.sv ----
module carc_rst import carc_pkg::*; #(
  parameter int HOLD_CYC = CARC_EXTERNAL_RESET_OUT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_request_in_b,
  // Internal reset and reset instruction
  output logic core_rst_b,
  input wire logic reset_instr,
  output logic external_reset_out
);
  logic s1_r;
  logic s2_r;
  logic [15:0] cnt_r;
  // Async assert, release synchronised to the clock edge
  always_ff @(posedge sys_clk or negedge reset_request_in_b) begin
    if (!reset_request_in_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= 1'b1;
      s2_r <= s1_r;
    end
  end
  assign core_rst_b = s2_r;
  always_ff @(posedge sys_clk or negedge s2_r) begin
    if (!s2_r) begin
      cnt_r <= '0;
    end else if (reset_instr && cnt_r == '0) begin
      cnt_r <= 16'(HOLD_CYC);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
  assign external_reset_out = (cnt_r != '0);
  external_reset_out_hold_a: assert property (@(posedge sys_clk) disable iff (!s2_r)
    $rose(external_reset_out) |-> external_reset_out [*8]) else $error("reset out too short");
endmodule

// ---- carc_top.sv ----
module carc_top import carc_pkg::*; #(
  parameter int EXTERNAL_RESET_OUT_CYC = CARC_EXTERNAL_RESET_OUT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_request_in_b,
  input wire logic reset_instr,
  output logic external_reset_out,
  // Core request: cache select, read/write, address, data
  input wire logic core_req,
  input wire logic core_isel,
  input wire logic core_we,
  input wire logic core_copyback,
  input wire logic core_nocache,
  input wire logic [31:0] core_addr,
  input wire logic [31:0] core_wdata,
  output logic core_ack,
  output logic [31:0] core_rdata,
  // Bus master side
  output logic bus_req,
  output logic bus_req_oe,
  output logic bus_we,
  output logic bus_burst,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic slave_no_cache_in,
  input wire logic burst_refuse_in,
  output logic no_cache_out,
  output logic [1:0] line_in_set_index,
  // Snoop side
  input wire logic snoop_valid,
  input wire logic snoop_we,
  input wire logic [1:0] snoop_op_select,
  input wire logic [31:0] snoop_addr,
  input wire logic [31:0] snoop_wdata,
  output logic memory_inhibit_out,
  output logic [31:0] snoop_rdata,
  output logic snoop_rdata_oe,
  // Cache control
  input wire logic cache_off_in
);
  localparam int LW = CARC_IDX_W + 2;
  // ********************************
  // Reset and storage
  // ********************************
  logic rst_b;
  carc_rst #(.HOLD_CYC(EXTERNAL_RESET_OUT_CYC)) u_rst (
    .sys_clk(sys_clk),
    .reset_request_in_b(reset_request_in_b),
    .core_rst_b(rst_b),
    .reset_instr(reset_instr),
    .external_reset_out(external_reset_out)
  );
  // Index [cache][way][set]; line words kept as a fourth index [word]
  logic [31:0] data_m [2][CARC_WAYS][CARC_SETS][CARC_WORDS];
  logic [CARC_TAG_W-1:0] tag_m [2][CARC_WAYS][CARC_SETS];
  logic valid_r [2][CARC_WAYS][CARC_SETS];
  logic dirty_r [CARC_WAYS][CARC_SETS];
  logic [1:0] rr_r [2][CARC_SETS];
  carc_state_t st_r;
  carc_state_t st_nxt;
  logic [1:0] wcnt_r;
  logic [1:0] way_r;
  logic cs_r;
  logic off_r;
  // ********************************
  // Lookup
  // ********************************
  function automatic logic [CARC_IDX_W-1:0] idx_of(input logic [31:0] a);
    return a[CARC_IDX_W+3:4];
  endfunction
  function automatic logic [CARC_TAG_W-1:0] tag_of(input logic [31:0] a);
    return a[31:CARC_IDX_W+4];
  endfunction
  wire logic cs = core_isel ? 1'b0 : 1'b1;
  wire logic [CARC_IDX_W-1:0] cidx = idx_of(core_addr);
  wire logic [CARC_IDX_W-1:0] sidx = idx_of(snoop_addr);
  logic [3:0] chit;
  logic [3:0] shit;
  always_comb begin
    for (int w = 0; w < CARC_WAYS; w++) begin
      chit[w] = valid_r[cs][w][cidx] && tag_m[cs][w][cidx] == tag_of(core_addr);
      shit[w] = valid_r[1][w][sidx] && tag_m[1][w][sidx] == tag_of(snoop_addr);
    end
  end
  function automatic logic [1:0] enc(input logic [3:0] h);
    return h[3] ? 2'd3 : h[2] ? 2'd2 : h[1] ? 2'd1 : 2'd0;
  endfunction
  wire logic [1:0] cway = enc(chit);
  wire logic [1:0] sway = enc(shit);
  wire logic [1:0] vict = rr_r[cs][cidx];
  wire logic vict_dirty = cs && valid_r[1][vict][cidx] && dirty_r[vict][cidx];
  // Cache-off sampled only between accesses; storage left intact
  wire logic uncached = off_r || core_nocache;
  wire logic hit = |chit && !uncached;
  wire logic is_snoop = snoop_valid && st_r == CARC_IDLE;
  // Snoop is independent of cache-off
  wire logic snp_src = is_snoop && !snoop_we && snoop_op_select == CARC_SNP_SRC
                       && |shit && dirty_r[sway][sidx];
  wire logic snp_upd = is_snoop && snoop_we && snoop_op_select != CARC_SNP_NONE && |shit;
  // ********************************
  // FIFO in the fill data path
  // ********************************
  logic f_in_ready;
  logic f_out_valid;
  logic [31:0] f_out_data;
  wire logic f_in_valid = st_r == CARC_FILL && bus_ack;
  carc_fifo #(.WIDTH(32), .DEPTH(CARC_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(bus_rdata),
    .out_valid(f_out_valid),
    .out_ready(1'b1),
    .out_data(f_out_data)
  );
  logic [1:0] fwr_r;
  logic fill_nc_r;
  // ********************************
  // Control
  // ********************************
  wire logic last_beat = bus_ack && wcnt_r == 2'd3;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      CARC_IDLE: begin
        if (snoop_valid) st_nxt = CARC_IDLE;
        else if (core_req && !hit && !uncached && vict_dirty && !(core_we && cs)) st_nxt = CARC_PUSH;
        else if (core_req && !hit && !(core_we && cs)) st_nxt = CARC_FILL;
        // Copyback write miss goes out as a single write, no allocate
        else if (core_req && core_we && cs && (!core_copyback || uncached || !hit)) st_nxt = CARC_WTHR;
      end
      CARC_PUSH: if (last_beat) st_nxt = CARC_FILL;
      CARC_FILL: if (bus_ack && (wcnt_r == 2'd3 || !bus_burst)) st_nxt = CARC_IDLE;
      CARC_WTHR: if (bus_ack) st_nxt = CARC_IDLE;
      default: st_nxt = CARC_IDLE;
    endcase
  end
  // Not sampled at reset: registered only while running
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= CARC_IDLE;
      wcnt_r <= CARC_WCNT_RST;
      way_r <= 2'h0;
      cs_r <= 1'b0;
      off_r <= 1'b0;
      fwr_r <= 2'h0;
      fill_nc_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == CARC_IDLE) off_r <= cache_off_in;
      if (st_r == CARC_IDLE) begin
        wcnt_r <= CARC_WCNT_RST;
        way_r <= vict;
        cs_r <= cs;
        fill_nc_r <= uncached;
      end else if (bus_ack) begin
        wcnt_r <= wcnt_r + 2'd1;
        if (st_r == CARC_FILL && slave_no_cache_in) fill_nc_r <= 1'b1;
      end
      if (st_r == CARC_IDLE) fwr_r <= 2'h0;
      else if (f_out_valid) fwr_r <= fwr_r + 2'd1;
    end
  end
  // ********************************
  // Array updates
  // ********************************
  wire logic wr_hit = st_r == CARC_IDLE && !snoop_valid && core_req && core_we && cs && hit;
  wire logic fill_done = st_r == CARC_FILL && last_beat && !fill_nc_r && !slave_no_cache_in;
  always_ff @(posedge sys_clk) begin
    if (f_out_valid && !fill_nc_r) data_m[cs_r][way_r][cidx][fwr_r] <= f_out_data;
    if (wr_hit) data_m[1][cway][cidx][core_addr[3:2]] <= core_wdata;
    if (snp_upd) data_m[1][sway][sidx][snoop_addr[3:2]] <= snoop_wdata;
    if (fill_done) tag_m[cs_r][way_r][cidx] <= tag_of(core_addr);
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < CARC_SETS; s++) begin
          rr_r[c][s] <= CARC_RR_RST;
          for (int w = 0; w < CARC_WAYS; w++) begin
            valid_r[c][w][s] <= 1'b0;
            if (c == 0) dirty_r[w][s] <= 1'b0;
          end
        end
      end
    end else begin
      // Off state only blocks use; entries untouched
      if (st_r == CARC_PUSH && last_beat) dirty_r[way_r][cidx] <= 1'b0;
      if (fill_done) begin
        valid_r[cs_r][way_r][cidx] <= 1'b1;
        rr_r[cs_r][cidx] <= way_r + 2'd1;
      end
      if (wr_hit && core_copyback) dirty_r[cway][cidx] <= 1'b1;
      if (snp_upd && snoop_op_select == CARC_SNP_INV) valid_r[1][sway][sidx] <= 1'b0;
    end
  end
  // ********************************
  // Outputs
  // ********************************
  wire logic active = st_r != CARC_IDLE;
  wire logic [31:0] line_base = {core_addr[31:4], 4'h0};
  wire logic [31:0] push_base = {tag_m[1][way_r][cidx], cidx, 4'h0};
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      snoop_rdata <= 32'h0000_0000;
      core_rdata <= 32'h0000_0000;
    end else begin
      if (snp_src) snoop_rdata <= data_m[1][sway][sidx][snoop_addr[3:2]];
      if (hit) core_rdata <= data_m[cs][cway][cidx][core_addr[3:2]];
      else if (st_r == CARC_FILL && bus_ack && (fill_nc_r || wcnt_r == core_addr[3:2])) core_rdata <= bus_rdata;
    end
  end
  // Reset drops all enables and negates others
  assign bus_req = active;
  assign bus_req_oe = active;
  assign bus_we = st_r == CARC_PUSH || st_r == CARC_WTHR;
  assign bus_burst = (st_r == CARC_PUSH || (st_r == CARC_FILL && !fill_nc_r)) && !burst_refuse_in;
  assign bus_addr = st_r == CARC_PUSH ? push_base + {28'h000_0000, wcnt_r, 2'h0}
                  : st_r == CARC_FILL && !fill_nc_r ? line_base + {28'h000_0000, wcnt_r, 2'h0} : core_addr;
  assign bus_wdata = st_r == CARC_PUSH ? data_m[1][way_r][cidx][wcnt_r] : core_wdata;
  assign line_in_set_index = (st_r == CARC_PUSH || st_r == CARC_FILL) ? way_r : 2'h0;
  assign no_cache_out = active && (fill_nc_r || st_r == CARC_WTHR);
  assign memory_inhibit_out = snp_src;
  assign snoop_rdata_oe = snp_src;
  assign core_ack = (st_r == CARC_IDLE && !snoop_valid && core_req && hit
                     && !(core_we && cs && !core_copyback))
                    || (st_r == CARC_FILL && st_nxt == CARC_IDLE)
                    || (st_r == CARC_WTHR && bus_ack);
  // ********************************
  // Checks
  // ********************************
  fill_four_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_r == CARC_FILL && bus_burst && last_beat) |=> st_r == CARC_IDLE) else $error("fill not four beats");
  tln_way_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_r == CARC_FILL |-> line_in_set_index == way_r) else $error("line index wrong");
  mi_src_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    memory_inhibit_out |-> snoop_op_select == CARC_SNP_SRC && !snoop_we) else $error("bad inhibit");
  mi_no_core_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    memory_inhibit_out |-> !bus_req) else $error("inhibit during own transfer");
  push_first_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_r == CARC_PUSH && last_beat) |=> st_r == CARC_FILL) else $error("push not followed by fill");
  dirty_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_hit && core_copyback) |=> dirty_r[$past(cway)][$past(cidx)]) else $error("dirty not set");
  off_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_r != CARC_IDLE |=> $stable(off_r)) else $error("cache off mid access");
  nc_wthr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_r == CARC_WTHR |-> no_cache_out && bus_we) else $error("writethrough qualifiers");
  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_r == CARC_IDLE |-> !bus_req_oe && !no_cache_out) else $error("outputs not negated");
  fill_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_b) fill_done);
  push_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_b) st_r == CARC_PUSH ##1 st_r == CARC_FILL);
  snoop_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_b) snp_src);
  off_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_b) off_r && core_req);
endmodule

// ---- carc_mem_model.sv ----
module carc_mem_model (
  // Clock
  input wire logic sys_clk,
  // Transfer from the device
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [1:0] line_in_set_index,
  // Slave answer
  output logic [31:0] bus_rdata,
  output logic bus_ack,
  output logic slave_no_cache_in,
  output logic burst_refuse_in,
  // Scenario controls
  input wire logic slow,
  input wire logic refuse,
  input wire logic no_cache
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_rd = 0;
  int n_wr = 0;
  int wait_cnt = 0;
  logic [31:0] last_wdata = 32'h0000_0000;
  logic [1:0] last_way = 2'h0;
  initial begin
    bus_rdata = 32'h0000_0000;
    bus_ack = 1'b0;
    slave_no_cache_in = 1'b0;
    burst_refuse_in = 1'b0;
  end
  // ****************************************
  // Beat log and slave answer
  // ****************************************
  always @(posedge sys_clk) begin
    if (bus_req && bus_ack) begin
      n_wr += bus_we;
      n_rd += !bus_we;
      last_way = line_in_set_index;
      if (bus_we) begin
        last_wdata = bus_wdata;
      end
    end
    if (bus_req && !bus_ack && wait_cnt >= (slow ? 2 : 0)) begin
      bus_ack <= 1'b1;
      bus_rdata <= bus_addr ^ 32'h5a5a_5a5a;
      slave_no_cache_in <= no_cache;
      burst_refuse_in <= refuse;
      wait_cnt = 0;
    end else begin
      // Released data flips so a stale word is never mistaken for a fresh one
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      slave_no_cache_in <= 1'b0;
      burst_refuse_in <= 1'b0;
      wait_cnt = bus_req ? wait_cnt + 1 : 0;
    end
  end
endmodule

// ---- tb.sv ----
module tb import carc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 8;
  localparam logic [31:0] A = 32'h0000_2048, D1 = 32'hc0de_0001, D2 = 32'hc0de_0002;
  localparam logic [31:0] E = 32'h0000_4000, F = 32'h0000_5010;
  logic sys_clk = 1'b0, reset_request_in_b = 1'b0, reset_instr = 1'b0, cache_off_in = 1'b0;
  logic core_req = 1'b0, core_isel = 1'b0, core_we = 1'b0, core_copyback = 1'b0, core_nocache = 1'b0;
  logic [31:0] core_addr = 32'h0000_0000, core_wdata = 32'h0000_0000;
  logic snoop_valid = 1'b0, snoop_we = 1'b0;
  logic [1:0] snoop_op_select = 2'h0;
  logic [31:0] snoop_addr = 32'h0000_0000, snoop_wdata = 32'h0000_0000;
  logic slow = 1'b0, refuse = 1'b0, no_cache = 1'b0;
  logic external_reset_out, core_ack, bus_req, bus_req_oe, bus_we, bus_burst, bus_ack;
  logic slave_no_cache_in, burst_refuse_in, no_cache_out, memory_inhibit_out, snoop_rdata_oe;
  logic [1:0] line_in_set_index;
  logic [31:0] core_rdata, bus_addr, bus_wdata, bus_rdata, snoop_rdata, ra, rn;
  logic inh, nc_seen;
  int n_fail = 0, n_checks = 0, r0 = 0, w0 = 0;
  wire logic [7:0] idle_v = {bus_req, bus_req_oe, memory_inhibit_out, snoop_rdata_oe,
                             external_reset_out, no_cache_out, line_in_set_index};
  always #5 sys_clk = ~sys_clk;

  carc_top #(.EXTERNAL_RESET_OUT_CYC(HOLD)) DUT (.sys_clk, .reset_request_in_b, .reset_instr, .external_reset_out,
    .core_req, .core_isel, .core_we, .core_copyback, .core_nocache, .core_addr, .core_wdata,
    .core_ack, .core_rdata, .bus_req, .bus_req_oe, .bus_we, .bus_burst, .bus_addr, .bus_wdata,
    .bus_rdata, .bus_ack, .slave_no_cache_in, .burst_refuse_in, .no_cache_out, .line_in_set_index,
    .snoop_valid, .snoop_we, .snoop_op_select, .snoop_addr, .snoop_wdata, .memory_inhibit_out,
    .snoop_rdata, .snoop_rdata_oe, .cache_off_in);
  carc_mem_model model (.sys_clk, .bus_req, .bus_we, .bus_addr, .bus_wdata, .line_in_set_index,
    .bus_rdata, .bus_ack, .slave_no_cache_in, .burst_refuse_in, .slow, .refuse, .no_cache);

  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic logic [31:0] pat(input logic [31:0] a);
    return a ^ 32'h5a5a_5a5a;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Request held until acknowledged; read data kept from ack cycle and the one after
  task automatic access(input logic we, input logic cb, input logic [31:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    nc_seen = 1'b0;
    r0 = model.n_rd;
    w0 = model.n_wr;
    @(posedge sys_clk);
    core_req <= 1'b1;
    core_we <= we;
    core_copyback <= cb;
    core_addr <= a;
    core_wdata <= wd;
    do begin
      @(negedge sys_clk);
      nc_seen |= no_cache_out;
      k++;
    end while (core_ack !== 1'b1 && k < 300);
    if (k >= 300) begin
      n_fail++;
      close_out();
    end
    ra = core_rdata;
    @(posedge sys_clk);
    core_req <= 1'b0;
    @(negedge sys_clk);
    rn = core_rdata;
  endtask
  task automatic snoop(input logic we, input logic [1:0] op, input logic [31:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    snoop_valid <= 1'b1;
    snoop_we <= we;
    snoop_op_select <= op;
    snoop_addr <= a;
    snoop_wdata <= wd;
    @(negedge sys_clk);
    inh = memory_inhibit_out;
    @(posedge sys_clk);
    snoop_valid <= 1'b0;
    @(negedge sys_clk);
    rn = snoop_rdata;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_fill();
    slow <= 1'b1;
    access(1'b0, 1'b1, A, 32'h0);
    check("fill data", rn, pat(A));
    check("fill beats", model.n_rd - r0, 32'h4);
    check("fill way", model.last_way, 32'h0);
    slow <= 1'b0;
    access(1'b0, 1'b1, A + 32'h4, 32'h0);
    check("hit data", rn, pat(A + 32'h4));
    check("hit beats", model.n_rd - r0, 32'h0);
    @(posedge sys_clk);
    core_isel <= 1'b1;
    access(1'b0, 1'b1, A, 32'h0);
    check("instruction fill beats", model.n_rd - r0, 32'h4);
    @(posedge sys_clk);
    core_isel <= 1'b0;
  endtask
  task automatic t_copyback();
    access(1'b1, 1'b1, A, D1);
    check("copyback bus writes", model.n_wr - w0, 32'h0);
    access(1'b0, 1'b1, A, 32'h0);
    check("copyback read", rn, D1);
    snoop(1'b0, CARC_SNP_NONE, A, 32'h0);
    check("idle snoop inhibit", inh, 1'b0);
    snoop(1'b0, CARC_SNP_SRC, A, 32'h0);
    check("snoop inhibit", inh, 1'b1);
    check("sourced data", rn, D1);
    snoop(1'b1, CARC_SNP_SRC, A + 32'h4, D2);
    access(1'b0, 1'b1, A + 32'h4, 32'h0);
    check("snoop update", rn, D2);
  endtask
  task automatic t_wthru();
    access(1'b1, 1'b0, 32'h0000_3000, D2);
    check("writethrough beats", model.n_wr - w0, 32'h1);
    check("writethrough data", model.last_wdata, D2);
  endtask
  task automatic t_off();
    @(posedge sys_clk);
    cache_off_in <= 1'b1;
    access(1'b0, 1'b1, A + 32'h8, 32'h0);
    check("bypass read", model.n_rd != r0, 1'b1);
    check("no-cache flag", nc_seen, 1'b1);
    snoop(1'b0, CARC_SNP_SRC, A, 32'h0);
    check("snoop while off", inh, 1'b1);
    @(posedge sys_clk);
    cache_off_in <= 1'b0;
    access(1'b0, 1'b1, A, 32'h0);
    check("kept line", rn, D1);
    check("kept line beats", model.n_rd - r0, 32'h0);
  endtask
  task automatic t_slave();
    refuse <= 1'b1;
    access(1'b0, 1'b1, E, 32'h0);
    check("refused burst beats", model.n_rd - r0, 32'h1);
    check("refused data", rn, pat(E));
    refuse <= 1'b0;
    no_cache <= 1'b1;
    access(1'b0, 1'b1, F, 32'h0);
    no_cache <= 1'b0;
    access(1'b0, 1'b1, F, 32'h0);
    check("uncached reread", model.n_rd != r0, 1'b1);
  endtask
  task automatic t_victim();
    int w;
    w = 0;
    for (int i = 1; i < 5; i++) begin
      access(1'b0, 1'b1, A + i * 32'h400, 32'h0);
      w += model.n_wr - w0;
    end
    check("dirty victim push", w, 32'h4);
  endtask
  task automatic t_reset();
    int k;
    k = 0;
    @(posedge sys_clk);
    reset_instr <= 1'b1;
    @(posedge sys_clk);
    reset_instr <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      k += external_reset_out;
    end
    check("reset-out length", k, HOLD);
    reset_instr <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset_instr <= 1'b0;
    reset_request_in_b <= 1'b0;
    @(negedge sys_clk);
    check("outputs in reset", {24'h00_0000, idle_v}, 32'h0000_0000);
    @(posedge sys_clk);
    reset_request_in_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    access(1'b0, 1'b1, A, 32'h0);
    check("refill after reset", model.n_rd - r0, 32'h4);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    reset_request_in_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check("idle outputs", {24'h00_0000, idle_v}, 32'h0000_0000);
    t_fill();
    t_copyback();
    t_wthru();
    t_off();
    t_slave();
    t_victim();
    t_reset();
    close_out();
  end
endmodule
